// ===== uic_map.svh
`ifndef UIC_MAP_SVH
`define UIC_MAP_SVH
// ------------------------------------------------------------------
// Object indices
// ------------------------------------------------------------------
`define OBJ_PULL 16'h2020
`define OBJ_DEBOUNCE 16'h2030
`define OBJ_RANGE 16'h2100
`define OBJ_PPR 16'h2101
`define OBJ_LP_POWER 16'h2120
`define OBJ_COEF_FIRST 16'h2121
`define OBJ_COEF_LAST 16'h2127
`define OBJ_ADC_REJECT 16'h2600
`define OBJ_STATE 16'h6020
`define OBJ_POLARITY 16'h6030
`define OBJ_SENSOR 16'h6110
`define OBJ_MODE 16'h6112
`define OBJ_FILTER 16'h61a0
`define OBJ_FCONST 16'h61a1
// ------------------------------------------------------------------
// Codes and limits
// ------------------------------------------------------------------
`define MODE_OFF 8'h00
`define MODE_ANALOG 8'h01
`define MODE_DIGITAL 8'h0a
`define MODE_ANA_ONOFF 8'h14
`define SENS_VOLTAGE 16'h0028
`define SENS_CURRENT 16'h0032
`define SENS_FREQ 16'h003c
`define SENS_RESIST 16'h0064
`define SENS_PWM 16'h2710
`define RANGE_MAX_VOLTAGE 8'h03
`define RANGE_MAX_FREQ 8'h02
`define RANGE_MAX_CUR_PWM 8'h01
`define RANGE_MAX_RESIST 8'h00
`define RANGE_DEFAULT 8'h00
`define PULL_NONE 8'h00
`define PULL_UP 8'h01
`define PULL_DOWN 8'h02
`define POL_NORMAL 8'h00
`define POL_INVERSE 8'h01
`define POL_LATCHED 8'h02
`define FILT_NONE 8'h00
`define FILT_MOVING 8'h01
`define FILT_REPEAT 8'h02
`define FILT_LOWPASS 8'h03
`define ADC_REJECT_MAX 8'h03
`define LP_POWER_MAX 16'h000f
`define DEBOUNCE_MAX 16'h03e8
`define RPM_FACTOR 32'h0000003c
// ------------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------------
`define RST_ADC_REJECT 8'h01
`define RST_MODE 8'h01
`define RST_DEBOUNCE 16'h000a
`define RST_FCONST 16'h000a
`define TICK_NS 1000000
`define CLK_NS 40
`define LP_TICKS 4'ha
`endif

// ===== uic_pkg.sv
package uic_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] index;
    logic [15:0] wdata;
  } obj_req_s;
  typedef struct packed {
    logic ack;
    logic nak;
    logic [15:0] rdata;
  } obj_rsp_s;
  typedef logic signed [15:0] sample_t;
endpackage

// ===== universal_input_conditioning.sv
`timescale 1ns/10ps
`default_nettype none
`include "uic_map.svh"
module universal_input_conditioning import uic_pkg::*; #(
  parameter int TICK_CYCLES = `TICK_NS / `CLK_NS
) (
  input wire logic clk,
  input wire logic srst,
  input wire obj_req_s obj_req,
  output obj_rsp_s obj_rsp,
  input wire logic univ_level,
  input wire logic ded_level,
  input wire logic sample_valid,
  input wire logic [15:0] sample,
  input wire sample_t field_value,
  input wire sample_t scale_low,
  input wire sample_t scale_high,
  output logic univ_state,
  output logic ded_state,
  output logic pullup_en,
  output logic pulldown_en,
  output logic adc_reject_en,
  output logic [1:0] adc_reject_sel,
  output logic rpm_mode,
  output sample_t filtered_value
);

  // ----------------------------------------------------------------
  // Configuration objects
  // ----------------------------------------------------------------
  logic [7:0] pull_sel;
  logic [15:0] debounce_interval;
  logic [7:0] input_range;
  logic [15:0] ppr;
  logic [7:0] adc_reject;
  logic [7:0] polarity;
  logic [15:0] sensor_type;
  logic [7:0] op_mode;
  logic [7:0] filter_type;
  logic [15:0] filter_const;
  logic [3:0] lp_power;
  sample_t coef [0:6];
  logic [7:0] logical_state;

  function automatic logic sensor_ok(input logic [15:0] t);
    sensor_ok = (t == `SENS_VOLTAGE) || (t == `SENS_CURRENT) ||
                (t == `SENS_FREQ) || (t == `SENS_RESIST) ||
                (t == `SENS_PWM);
  endfunction

  function automatic logic [7:0] range_max(input logic [15:0] t);
    case (t)
      `SENS_VOLTAGE: range_max = `RANGE_MAX_VOLTAGE;
      `SENS_FREQ: range_max = `RANGE_MAX_FREQ;
      `SENS_RESIST: range_max = `RANGE_MAX_RESIST;
      default: range_max = `RANGE_MAX_CUR_PWM;
    endcase
  endfunction

  logic wr_ok;
  logic [7:0] wlo;
  assign wlo = obj_req.wdata[7:0];

  always_comb begin
    wr_ok = 1'b1;
    case (obj_req.index)
      `OBJ_PULL: wr_ok = (obj_req.wdata <= 16'(`PULL_DOWN));
      `OBJ_DEBOUNCE: wr_ok = (obj_req.wdata <= `DEBOUNCE_MAX);
      `OBJ_RANGE: wr_ok = (obj_req.wdata <=
                           16'(range_max(sensor_type)));
      `OBJ_PPR: wr_ok = 1'b1;
      `OBJ_LP_POWER: wr_ok = (obj_req.wdata <= `LP_POWER_MAX);
      `OBJ_ADC_REJECT: wr_ok = (obj_req.wdata <=
                                16'(`ADC_REJECT_MAX));
      `OBJ_POLARITY: wr_ok = (obj_req.wdata <= 16'(`POL_LATCHED));
      `OBJ_SENSOR: wr_ok = sensor_ok(obj_req.wdata);
      `OBJ_MODE: wr_ok = (obj_req.wdata == 16'(`MODE_OFF)) ||
                         (obj_req.wdata == 16'(`MODE_ANALOG)) ||
                         (obj_req.wdata == 16'(`MODE_DIGITAL)) ||
                         (obj_req.wdata == 16'(`MODE_ANA_ONOFF));
      `OBJ_FILTER: wr_ok = (obj_req.wdata <= 16'(`FILT_LOWPASS));
      `OBJ_FCONST: wr_ok = (obj_req.wdata != 16'h0000);
      default: wr_ok = (obj_req.index >= `OBJ_COEF_FIRST) &&
                       (obj_req.index <= `OBJ_COEF_LAST);
    endcase
  end

  logic do_wr;
  assign do_wr = obj_req.wr && wr_ok;

  always_ff @(posedge clk) begin
    if (srst) begin
      pull_sel <= `PULL_NONE;
      debounce_interval <= `RST_DEBOUNCE;
      input_range <= `RANGE_DEFAULT;
      ppr <= 16'h0000;
      adc_reject <= `RST_ADC_REJECT;
      polarity <= `POL_NORMAL;
      sensor_type <= `SENS_VOLTAGE;
      op_mode <= `RST_MODE;
      filter_type <= `FILT_NONE;
      filter_const <= `RST_FCONST;
      lp_power <= 4'h0;
    end else if (do_wr) begin
      case (obj_req.index)
        `OBJ_PULL: pull_sel <= wlo;
        `OBJ_DEBOUNCE: debounce_interval <= obj_req.wdata;
        `OBJ_RANGE: input_range <= wlo;
        `OBJ_PPR: ppr <= obj_req.wdata;
        `OBJ_LP_POWER: lp_power <= obj_req.wdata[3:0];
        `OBJ_ADC_REJECT: adc_reject <= wlo;
        `OBJ_POLARITY: polarity <= wlo;
        `OBJ_SENSOR: begin
          sensor_type <= obj_req.wdata;
          input_range <= `RANGE_DEFAULT;
        end
        `OBJ_MODE: op_mode <= wlo;
        `OBJ_FILTER: filter_type <= wlo;
        `OBJ_FCONST: filter_const <= obj_req.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < 7; i++) begin
        coef[i] <= 16'sh0000;
      end
    end else if (do_wr && obj_req.index >= `OBJ_COEF_FIRST &&
                 obj_req.index <= `OBJ_COEF_LAST) begin
      coef[3'(obj_req.index - `OBJ_COEF_FIRST)] <= obj_req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Object response
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      obj_rsp <= '0;
    end else begin
      obj_rsp.ack <= (obj_req.wr && wr_ok) || obj_req.rd;
      obj_rsp.nak <= obj_req.wr && !wr_ok;
      if (obj_req.rd) begin
        case (obj_req.index)
          `OBJ_PULL: obj_rsp.rdata <= {8'h00, pull_sel};
          `OBJ_DEBOUNCE: obj_rsp.rdata <= debounce_interval;
          `OBJ_RANGE: obj_rsp.rdata <= {8'h00, input_range};
          `OBJ_PPR: obj_rsp.rdata <= ppr;
          `OBJ_LP_POWER: obj_rsp.rdata <= {12'h000, lp_power};
          `OBJ_ADC_REJECT: obj_rsp.rdata <= {8'h00, adc_reject};
          `OBJ_STATE: obj_rsp.rdata <= {8'h00, logical_state};
          `OBJ_POLARITY: obj_rsp.rdata <= {8'h00, polarity};
          `OBJ_SENSOR: obj_rsp.rdata <= sensor_type;
          `OBJ_MODE: obj_rsp.rdata <= {8'h00, op_mode};
          `OBJ_FILTER: obj_rsp.rdata <= {8'h00, filter_type};
          `OBJ_FCONST: obj_rsp.rdata <= filter_const;
          default: begin
            if (obj_req.index >= `OBJ_COEF_FIRST &&
                obj_req.index <= `OBJ_COEF_LAST) begin
              obj_rsp.rdata <= coef[3'(obj_req.index - `OBJ_COEF_FIRST)];
            end else begin
              obj_rsp.rdata <= 16'h0000;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Millisecond tick and 10 ms divider
  // ----------------------------------------------------------------
  localparam int TW = $clog2(TICK_CYCLES + 1);
  logic [TW-1:0] tick_cnt;
  logic tick;
  logic [3:0] lp_cnt;
  logic lp_tick;

  always_ff @(posedge clk) begin
    if (srst) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == TW'(TICK_CYCLES - 1));
      if (tick_cnt == TW'(TICK_CYCLES - 1)) begin
        tick_cnt <= '0;
      end else begin
        tick_cnt <= tick_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      lp_cnt <= 4'h0;
      lp_tick <= 1'b0;
    end else begin
      lp_tick <= tick && (lp_cnt == `LP_TICKS - 4'h1);
      if (tick) begin
        lp_cnt <= (lp_cnt == `LP_TICKS - 4'h1) ? 4'h0 : lp_cnt + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Debounce, index 0 universal, index 1 dedicated
  // ----------------------------------------------------------------
  logic [1:0] lvl;
  logic [1:0] dbn_en;
  logic [1:0] prev_lvl;
  logic [1:0] accepted;
  logic [15:0] dcnt [0:1];

  assign lvl = {ded_level, univ_level};
  assign dbn_en = {1'b1, op_mode == `MODE_DIGITAL};

  always_ff @(posedge clk) begin
    if (srst) begin
      prev_lvl <= 2'b00;
      accepted <= 2'b00;
      dcnt[0] <= 16'h0000;
      dcnt[1] <= 16'h0000;
    end else begin
      for (int i = 0; i < 2; i++) begin
        prev_lvl[i] <= lvl[i];
        if (!dbn_en[i]) begin
          dcnt[i] <= 16'h0000;
          accepted[i] <= 1'b0;
        end else if (lvl[i] != prev_lvl[i]) begin
          dcnt[i] <= 16'h0000;
        end else if (dcnt[i] >= debounce_interval) begin
          if (lvl[i] != accepted[i]) begin
            accepted[i] <= lvl[i];
          end
        end else if (tick) begin
          dcnt[i] <= dcnt[i] + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Sense, polarity and logical state
  // ----------------------------------------------------------------
  logic [1:0] active;
  logic [1:0] prev_active;
  logic [1:0] disc_state;
  logic hyst_state;

  assign active[0] = accepted[0];
  assign active[1] = (pull_sel == `PULL_UP) ? !accepted[1] :
                     accepted[1];

  always_ff @(posedge clk) begin
    if (srst) begin
      pullup_en <= 1'b0;
      pulldown_en <= 1'b0;
    end else begin
      pullup_en <= (pull_sel == `PULL_UP);
      pulldown_en <= (pull_sel == `PULL_DOWN);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      prev_active <= 2'b00;
      disc_state <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        prev_active[i] <= active[i];
        case (polarity)
          `POL_NORMAL: disc_state[i] <= active[i];
          `POL_INVERSE: disc_state[i] <= !active[i];
          `POL_LATCHED: begin
            if (active[i] && !prev_active[i]) begin
              disc_state[i] <= !disc_state[i];
            end
          end
          default: disc_state[i] <= active[i];
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      hyst_state <= 1'b0;
    end else if (op_mode != `MODE_ANA_ONOFF) begin
      hyst_state <= 1'b0;
    end else if (field_value >= scale_high) begin
      hyst_state <= 1'b1;
    end else if (field_value <= scale_low) begin
      hyst_state <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      univ_state <= 1'b0;
      ded_state <= 1'b0;
    end else begin
      ded_state <= disc_state[1];
      case (op_mode)
        `MODE_DIGITAL: univ_state <= disc_state[0];
        `MODE_ANA_ONOFF: univ_state <= hyst_state;
        default: univ_state <= 1'b0;
      endcase
    end
  end

  assign logical_state = {7'h00, univ_state};

  // ----------------------------------------------------------------
  // Converter options and measurement
  // ----------------------------------------------------------------
  logic rpm_sel;
  logic [31:0] rpm_full;
  sample_t latest;

  assign rpm_sel = (sensor_type == `SENS_FREQ) && (ppr != 16'h0000);
  assign rpm_full = rpm_sel ?
                    (32'(sample) * `RPM_FACTOR) / 32'(ppr) : 32'h0;

  always_ff @(posedge clk) begin
    if (srst) begin
      adc_reject_en <= 1'b0;
      adc_reject_sel <= 2'b00;
      rpm_mode <= 1'b0;
    end else begin
      adc_reject_en <= (sensor_type == `SENS_VOLTAGE) ||
                       (sensor_type == `SENS_CURRENT) ||
                       (sensor_type == `SENS_RESIST);
      adc_reject_sel <= adc_reject[1:0];
      rpm_mode <= rpm_sel;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      latest <= 16'sh0000;
    end else if (sample_valid) begin
      latest <= rpm_sel ? rpm_full[15:0] : sample;
    end
  end

  // ----------------------------------------------------------------
  // Software filters
  // ----------------------------------------------------------------
  sample_t avg;
  logic signed [16:0] avg_diff;
  logic signed [16:0] avg_step;
  logic signed [31:0] rep_sum;
  logic signed [31:0] rep_sum_next;
  logic signed [31:0] rep_mean;
  logic [15:0] rep_cnt;
  sample_t xin [0:3];
  sample_t yout [1:3];
  logic signed [35:0] lp_acc;
  logic signed [35:0] lp_shift;

  assign avg_diff = 17'(latest) - 17'(avg);
  assign avg_step = avg_diff / $signed({1'b0, filter_const});
  assign rep_sum_next = rep_sum + 32'(latest);
  assign rep_mean = rep_sum_next / $signed({16'h0000, filter_const});

  always_comb begin
    lp_acc = 36'(coef[0]) * 36'(latest);
    for (int k = 1; k < 4; k++) begin
      lp_acc = lp_acc + 36'(coef[k]) * 36'(xin[k]);
      lp_acc = lp_acc + 36'(coef[k+3]) * 36'(yout[k]);
    end
  end
  assign lp_shift = lp_acc >>> lp_power;

  always_ff @(posedge clk) begin
    if (srst || filter_type != `FILT_MOVING) begin
      avg <= latest;
    end else if (tick) begin
      avg <= avg + avg_step[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst || filter_type != `FILT_REPEAT) begin
      rep_sum <= 32'sh0;
      rep_cnt <= 16'h0000;
    end else if (tick) begin
      if (rep_cnt + 16'h0001 >= filter_const) begin
        rep_sum <= 32'sh0;
        rep_cnt <= 16'h0000;
      end else begin
        rep_sum <= rep_sum_next;
        rep_cnt <= rep_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int k = 0; k < 4; k++) begin
        xin[k] <= 16'sh0000;
      end
      for (int k = 1; k < 4; k++) begin
        yout[k] <= 16'sh0000;
      end
    end else if (lp_tick && filter_type == `FILT_LOWPASS) begin
      xin[1] <= latest;
      xin[2] <= xin[1];
      xin[3] <= xin[2];
      yout[1] <= lp_shift[15:0];
      yout[2] <= yout[1];
      yout[3] <= yout[2];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      filtered_value <= 16'sh0000;
    end else begin
      case (filter_type)
        `FILT_NONE: filtered_value <= latest;
        `FILT_MOVING: begin
          if (tick) begin
            filtered_value <= avg + avg_step[15:0];
          end
        end
        `FILT_REPEAT: begin
          if (tick && rep_cnt + 16'h0001 >= filter_const) begin
            filtered_value <= rep_mean[15:0];
          end
        end
        `FILT_LOWPASS: begin
          if (lp_tick) begin
            filtered_value <= lp_shift[15:0];
          end
        end
        default: filtered_value <= latest;
      endcase
    end
  end

endmodule // universal_input_conditioning
`default_nettype wire

// ===== uic_checker_properties.sv
`timescale 1ns/10ps
`default_nettype none
module uic_checker import uic_pkg::*; #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic clk,
  input wire logic srst,
  input wire obj_req_s obj_req,
  input wire obj_rsp_s obj_rsp,
  input wire logic pullup_en,
  input wire logic pulldown_en,
  input wire logic adc_reject_en,
  input wire logic rpm_mode
);
  // ----
  // Object port answers and output relations
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic w;
  logic [15:0] i;
  logic [15:0] d;
  assign w = obj_req.wr;
  assign i = obj_req.index;
  assign d = obj_req.wdata;
  property p_state_ro;
    w && i == 16'h6020 |=> obj_rsp.nak && !obj_rsp.ack;
  endproperty
  a_state_ro: assert property (p_state_ro)
    else $error("state write not refused");
  property p_mode_codes;
    w && i == 16'h6112 |=>
      obj_rsp.nak == !($past(d) inside {16'h0, 16'h1, 16'ha, 16'h14});
  endproperty
  a_mode_codes: assert property (p_mode_codes)
    else $error("mode write answer wrong");
  property p_sensor_codes;
    w && i == 16'h6110 |=> obj_rsp.nak ==
      !($past(d) inside {16'h28, 16'h32, 16'h3c, 16'h64, 16'h2710});
  endproperty
  a_sensor_codes: assert property (p_sensor_codes)
    else $error("sensor write answer wrong");
  property p_range_cap;
    w && i == 16'h2100 && d > 16'h3 |=> obj_rsp.nak;
  endproperty
  a_range_cap: assert property (p_range_cap)
    else $error("range above 3 accepted");
  property p_pull_codes;
    w && i == 16'h2020 |=> obj_rsp.nak == ($past(d) > 16'h2);
  endproperty
  a_pull_codes: assert property (p_pull_codes)
    else $error("pull write answer wrong");
  property p_debounce_max;
    w && i == 16'h2030 |=> obj_rsp.nak == ($past(d) > 16'h3e8);
  endproperty
  a_debounce_max: assert property (p_debounce_max)
    else $error("debounce write answer wrong");
  property p_filter_codes;
    w && i == 16'h61a0 |=> obj_rsp.nak == ($past(d) > 16'h3);
  endproperty
  a_filter_codes: assert property (p_filter_codes)
    else $error("filter write answer wrong");
  property p_pull_excl;
    !(pullup_en && pulldown_en);
  endproperty
  a_pull_excl: assert property (p_pull_excl)
    else $error("both pull resistors on");
  property p_rpm_no_adc;
    rpm_mode |-> !adc_reject_en;
  endproperty
  a_rpm_no_adc: assert property (p_rpm_no_adc)
    else $error("rejection on frequency input");
endmodule // uic_checker
bind universal_input_conditioning uic_checker #(
  .TICK_CYCLES(TICK_CYCLES)
) chk_u (
  .clk(clk),
  .srst(srst),
  .obj_req(obj_req),
  .obj_rsp(obj_rsp),
  .pullup_en(pullup_en),
  .pulldown_en(pulldown_en),
  .adc_reject_en(adc_reject_en),
  .rpm_mode(rpm_mode)
);
`default_nettype wire

// ===== uic_field_model.sv
`timescale 1ns/10ps
`default_nettype none
module uic_field_model (
  input wire logic clk,
  input wire logic univ_closed,
  input wire logic ded_closed,
  input wire logic pullup_en,
  input wire logic pulldown_en,
  input wire logic [15:0] sensor_value,
  output logic univ_level,
  output logic ded_level,
  output logic sample_valid,
  output logic [15:0] sample
);
  // ----
  // Switches and converter
  // ----
  logic [1:0] phase = 2'h0;
  logic float_bit = 1'b0;
  assign univ_level = univ_closed;
  always_comb begin
    if (ded_closed) begin
      ded_level = !pullup_en;
    end else if (pullup_en) begin
      ded_level = 1'b1;
    end else if (pulldown_en) begin
      ded_level = 1'b0;
    end else begin
      ded_level = float_bit;
    end
  end
  always_ff @(posedge clk) begin
    phase <= phase + 2'h1;
    float_bit <= !float_bit;
  end
  // Bus carries junk outside the strobe
  assign sample_valid = (phase == 2'h0);
  assign sample = sample_valid ? sensor_value : ~sensor_value;
endmodule // uic_field_model
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench import uic_pkg::*;;
  // ----
  // Signals
  // ----
  localparam int TC = 10;
  localparam logic [15:0] SENS [5] = '{16'h32, 16'h3c, 16'h64, 16'h2710,
                                       16'h28};
  localparam logic [15:0] RMAX [5] = '{16'h1, 16'h2, 16'h0, 16'h1, 16'h3};
  localparam logic [4:0] ADCEN = 5'b10101;
  localparam logic [15:0] MODES [4] = '{16'h0, 16'h1, 16'h14, 16'ha};
  logic clk = 1'b0;
  logic srst = 1'b1;
  obj_req_s obj_req = '0;
  obj_rsp_s obj_rsp;
  logic univ_level, ded_level, sample_valid, univ_state, ded_state;
  logic pullup_en, pulldown_en, adc_reject_en, rpm_mode;
  logic [1:0] adc_reject_sel;
  logic [15:0] sample;
  sample_t field_value = '0;
  sample_t scale_low = 16'sd100;
  sample_t scale_high = 16'sd200;
  sample_t filtered_value;
  logic univ_closed = 1'b0;
  logic ded_closed = 1'b0;
  logic [15:0] sensor_value = '0;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  always #20 clk = !clk;
  universal_input_conditioning #(.TICK_CYCLES(TC)) dut_u (
    .clk(clk), .srst(srst), .obj_req(obj_req), .obj_rsp(obj_rsp),
    .univ_level(univ_level), .ded_level(ded_level),
    .sample_valid(sample_valid), .sample(sample),
    .field_value(field_value), .scale_low(scale_low), .scale_high(scale_high),
    .univ_state(univ_state), .ded_state(ded_state), .pullup_en(pullup_en),
    .pulldown_en(pulldown_en), .adc_reject_en(adc_reject_en),
    .adc_reject_sel(adc_reject_sel), .rpm_mode(rpm_mode),
    .filtered_value(filtered_value));
  uic_field_model model_u (
    .clk(clk), .univ_closed(univ_closed), .ded_closed(ded_closed),
    .pullup_en(pullup_en), .pulldown_en(pulldown_en),
    .sensor_value(sensor_value), .univ_level(univ_level),
    .ded_level(ded_level), .sample_valid(sample_valid), .sample(sample));
  // ----
  // Tasks
  // ----
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bit_chk(input logic got, input logic exp);
    chk({15'h0, got}, {15'h0, exp});
  endtask
  task automatic access(input logic r, input logic [15:0] idx,
                        input logic [15:0] d, output logic [17:0] rsp);
    @(posedge clk);
    obj_req <= '{wr: !r, rd: r, index: idx, wdata: d};
    @(posedge clk);
    obj_req <= '0;
    @(posedge clk);
    rsp = {obj_rsp.ack, obj_rsp.nak, obj_rsp.rdata};
  endtask
  task automatic wr(input logic [15:0] idx, input logic [15:0] d,
                    input logic nak);
    logic [17:0] rsp;
    access(1'b0, idx, d, rsp);
    chk({14'h0, rsp[17:16]}, {14'h0, !nak, nak});
  endtask
  task automatic rd(input logic [15:0] idx, input logic [15:0] exp);
    logic [17:0] rsp;
    access(1'b1, idx, 16'h0, rsp);
    chk({14'h0, rsp[17:16]}, 16'h2);
    chk(rsp[15:0], exp);
  endtask
  task automatic ticks(input int n);
    repeat (n * TC) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      wrap_up();
    end
  end
  // ----
  // Sequence
  // ----
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd(16'h2600, 16'h1);
    rd(16'h6030, 16'h0);
    rd(16'h6110, 16'h28);
    rd(16'h61a0, 16'h0);
    rd(16'h61a1, 16'ha);
    wr(16'h6020, 16'h1, 1'b1);
    wr(16'h6112, 16'h2, 1'b1);
    wr(16'h6110, 16'h29, 1'b1);
    wr(16'h2030, 16'h3e9, 1'b1);
    wr(16'h2030, 16'h3e8, 1'b0);
    rd(16'h2030, 16'h3e8);
    wr(16'h6030, 16'h3, 1'b1);
    wr(16'h61a0, 16'h4, 1'b1);
    wr(16'h2020, 16'h3, 1'b1);
    foreach (MODES[k]) wr(16'h6112, MODES[k], 1'b0);
    wr(16'h2100, 16'h3, 1'b0);
    for (int k = 0; k < 5; k++) begin
      wr(16'h6110, SENS[k], 1'b0);
      rd(16'h2100, 16'h0);
      wr(16'h2100, RMAX[k], 1'b0);
      wr(16'h2100, RMAX[k] + 16'h1, 1'b1);
      rd(16'h2100, RMAX[k]);
      bit_chk(adc_reject_en, ADCEN[4 - k]);
    end
    wr(16'h2600, 16'h3, 1'b0);
    wr(16'h2600, 16'h4, 1'b1);
    chk({14'h0, adc_reject_sel}, 16'h3);
    wr(16'h6110, 16'h3c, 1'b0);
    wr(16'h2101, 16'h2, 1'b0);
    sensor_value <= 16'ha;
    ticks(2);
    bit_chk(rpm_mode, 1'b1);
    chk(filtered_value, 16'd300);
    wr(16'h6110, 16'h28, 1'b0);
    sensor_value <= 16'd1234;
    ticks(2);
    bit_chk(rpm_mode, 1'b0);
    chk(filtered_value, 16'd1234);
    wr(16'h61a1, 16'h2, 1'b0);
    wr(16'h61a0, 16'h1, 1'b0);
    sensor_value <= 16'd800;
    ticks(30);
    bit_chk(filtered_value >= 799 && filtered_value <= 801, 1'b1);
    wr(16'h61a1, 16'h4, 1'b0);
    wr(16'h61a0, 16'h2, 1'b0);
    sensor_value <= 16'd400;
    ticks(10);
    chk(filtered_value, 16'd400);
    wr(16'h2121, 16'h1, 1'b0);
    wr(16'h2120, 16'h0, 1'b0);
    wr(16'h61a0, 16'h3, 1'b0);
    ticks(45);
    chk(filtered_value, 16'd400);
    wr(16'h2030, 16'h2, 1'b0);
    univ_closed <= 1'b1;
    ticks(4);
    bit_chk(univ_state, 1'b1);
    univ_closed <= 1'b0;
    ticks(1);
    bit_chk(univ_state, 1'b1);
    univ_closed <= 1'b1;
    ticks(4);
    bit_chk(univ_state, 1'b1);
    wr(16'h6112, 16'h1, 1'b0);
    ticks(1);
    bit_chk(univ_state, 1'b0);
    wr(16'h6112, 16'h0, 1'b0);
    wr(16'h2020, 16'h1, 1'b0);
    ticks(4);
    bit_chk(pullup_en, 1'b1);
    bit_chk(ded_state, 1'b0);
    ded_closed <= 1'b1;
    ticks(4);
    bit_chk(ded_state, 1'b1);
    wr(16'h2020, 16'h2, 1'b0);
    ticks(4);
    bit_chk(pulldown_en, 1'b1);
    bit_chk(ded_state, 1'b1);
    ded_closed <= 1'b0;
    ticks(4);
    bit_chk(ded_state, 1'b0);
    wr(16'h6112, 16'ha, 1'b0);
    wr(16'h6030, 16'h1, 1'b0);
    ticks(4);
    bit_chk(univ_state, 1'b0);
    wr(16'h6030, 16'h2, 1'b0);
    univ_closed <= 1'b0;
    ticks(4);
    bit_chk(univ_state, 1'b0);
    univ_closed <= 1'b1;
    ticks(4);
    bit_chk(univ_state, 1'b1);
    univ_closed <= 1'b0;
    ticks(4);
    bit_chk(univ_state, 1'b1);
    univ_closed <= 1'b1;
    ticks(4);
    bit_chk(univ_state, 1'b0);
    wr(16'h6112, 16'h14, 1'b0);
    field_value <= 16'sd250;
    ticks(1);
    bit_chk(univ_state, 1'b1);
    rd(16'h6020, 16'h1);
    field_value <= 16'sd150;
    ticks(1);
    bit_chk(univ_state, 1'b1);
    field_value <= 16'sd50;
    ticks(1);
    bit_chk(univ_state, 1'b0);
    field_value <= 16'sd150;
    ticks(1);
    bit_chk(univ_state, 1'b0);
    scale_high <= 16'sd120;
    ticks(1);
    bit_chk(univ_state, 1'b1);
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
